/* inc/tmr_pkg.sv */
/*
  Constants, field positions and carrier types for the timer block:
  two reloading down-counters, the high and low pulse width timers,
  the IR/PWM output, the time base counter and the interrupt flags.
  Assumes one 20 MHz clock, mclk, and register access from the core
  through the I/O control pages and the register file.
*/
package tmr_pkg;

  // Register spaces and addresses
  localparam logic [1:0] SPACE_IOC0  = 2'h0;
  localparam logic [1:0] SPACE_IOC1  = 2'h1;
  localparam logic [1:0] SPACE_RFILE = 2'h2;
  localparam logic [3:0] A_CNT1_PRESET  = 4'hB;
  localparam logic [3:0] A_CNT2_PRESET  = 4'hC;
  localparam logic [3:0] A_HIGH_PRESET  = 4'hD;
  localparam logic [3:0] A_LOW_PRESET   = 4'hE;
  localparam logic [3:0] A_IRQ_MASK     = 4'hF;
  localparam logic [3:0] A_TB_CONTROL   = 4'h7;
  localparam logic [3:0] A_CNT12_CTRL   = 4'h9;
  localparam logic [3:0] A_PULSE_CTRL   = 4'hA;
  localparam logic [3:0] A_TB_COUNTER   = 4'h1;
  localparam logic [3:0] A_COUNTER_RUN  = 4'hC;
  localparam logic [3:0] A_IR_CONTROL   = 4'hE;
  localparam logic [3:0] A_IRQ_STATUS   = 4'hF;

  localparam logic [7:0] RST_BYTE      = 8'h00;
  localparam logic [7:0] PS_MASK_BASE  = 8'hFE;
  localparam logic [7:0] TB_MAX        = 8'hFF;

  // Channel numbers of the four down-counters
  localparam int CH_CNT1 = 0;
  localparam int CH_CNT2 = 1;
  localparam int CH_HIGH = 2;
  localparam int CH_LOW  = 3;
  localparam int NUM_CH  = 4;

  // Status and mask bit positions
  localparam int ST_TB      = 0;
  localparam int ST_EXT0    = 1;
  localparam int ST_EXT1    = 2;
  localparam int ST_CH_BASE = 3;
  localparam int ST_PORT    = 7;

  // Time base control fields
  localparam int TB_INT_EDGE = 7;
  localparam int TB_GIE      = 6;
  localparam int TB_SRC      = 5;
  localparam int TB_EDGE     = 4;
  localparam int TB_PS_ON    = 3;
  localparam int TB_PS_HI    = 2;

  // IR control fields
  localparam int IR_ENABLE   = 7;
  localparam int IR_MOD_EN   = 6;
  localparam int IR_LOW_ONLY = 5;
  localparam int IR_PIN_EN   = 3;
  localparam int IR_EXT0_EN  = 0;
  localparam logic [7:0] IR_WR_MASK = 8'hEF;

  // Per-channel nibble in the clock control registers
  localparam int CK_SRC   = 3;
  localparam int CK_PS_HI = 2;
  localparam int NIB      = 4;

  typedef struct packed {
    logic       we;
    logic       re;
    logic [1:0] space;
    logic [3:0] addr;
    logic [7:0] wdata;
  } tmr_reg_req_t;

  typedef struct packed {
    logic fs;
    logic fm;
    logic instr;
  } tmr_ticks_t;

  typedef struct packed {
    logic irqOff;
    logic irqOn;
    logic irqRet;
    logic irqEntry;
  } tmr_gie_ctl_t;

  typedef enum logic [0:0] {
    PH_HIGH = 1'b0,
    PH_LOW  = 1'b1
  } tmr_phase_t;

endpackage

/* rtl/tmr_down_counter.sv */
/*
  One 8-bit reloading down-counter with a 1:2..1:256 prescaler.
  Assumes srcTick is a one-cycle pulse on mclk from the chosen source.
*/
`timescale 1ns/100ps
module tmr_down_counter (
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  input  wire logic       run,
  input  wire logic       srcTick,
  input  wire logic [2:0] psCode,
  input  wire logic [7:0] preset,
  output logic            underflow,
  output logic [7:0]      count
);
  import tmr_pkg::*;

  logic [7:0] psCnt;
  logic [7:0] psLimit;
  logic       tick;

  assign psLimit = ~(8'(PS_MASK_BASE << psCode));
  assign tick    = run && srcTick && (psCnt == psLimit);

  // Prescaler
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      psCnt <= RST_BYTE;
    end else if (!run || tick) begin
      psCnt <= RST_BYTE;
    end else if (srcTick) begin
      psCnt <= psCnt + 8'h01;
    end
  end

  // Counter with reload on underflow
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      count     <= RST_BYTE;
      underflow <= 1'b0;
    end else begin
      underflow <= 1'b0;
      if (!run) begin
        count <= preset;
      end else if (tick) begin
        if (count == RST_BYTE) begin
          count     <= preset;
          underflow <= 1'b1;
        end else begin
          count <= count - 8'h01;
        end
      end
    end
  end

endmodule

/* rtl/tmr_timer_block.sv */
/*
  Timer block top: register port, four down-counters, IR/PWM output,
  time base counter, status flags and the interrupt request.
  Assumes ticks and instruction strobes come from mclk logic; the
  external count pin and the external interrupt 0 pin are asynchronous.
*/
`timescale 1ns/100ps
module tmr_timer_block (
  input  wire logic                  mclk,
  input  wire logic                  sys_rst,
  input  wire tmr_pkg::tmr_reg_req_t regReq,
  input  wire tmr_pkg::tmr_ticks_t   ticks,
  input  wire tmr_pkg::tmr_gie_ctl_t gieCtl,
  input  wire logic                  extCountPin,
  input  wire logic                  extIrq0Pin,
  input  wire logic                  extIrq1Evt,
  input  wire logic                  portChangeEvt,
  output logic [7:0]                 regRdata,
  output logic                       irOutputPin,
  output logic                       irOutputEn,
  output logic                       irqReq
);
  import tmr_pkg::*;

  logic [7:0]  preset [NUM_CH];
  logic [7:0]  cntVal [NUM_CH];
  logic [NUM_CH-1:0] uf;
  logic [NUM_CH-1:0] chRun;
  logic [7:0]  irqEnableMask;
  logic [7:0]  timeBaseControl;
  logic [7:0]  cnt12Ctrl;
  logic [7:0]  pulseCtrl;
  logic [3:0]  counterRun;
  logic [7:0]  irControl;
  logic [7:0]  irqStatus;
  logic [7:0]  timeBaseCounter;
  logic [7:0]  tbPsCnt;
  logic        globalIrqEn;
  logic        carrier;
  tmr_phase_t  phase;
  logic        next_ir_output_pin;
  logic        extSync1;
  logic        extSync2;
  logic        extSync3;
  logic        i0Sync1;
  logic        i0Sync2;
  logic        i0Sync3;
  logic        extEdge;
  logic        ext0Edge;
  logic        tbEvent;
  logic        tbTick;
  logic [7:0]  tbPsLimit;
  logic [7:0]  setEvents;
  logic [7:0]  next_rdata;
  logic        irOn;
  logic        wrIoc0;
  logic        wrIoc1;
  logic        wrRfile;

  assign wrIoc0  = regReq.we && (regReq.space == SPACE_IOC0);
  assign wrIoc1  = regReq.we && (regReq.space == SPACE_IOC1);
  assign wrRfile = regReq.we && (regReq.space == SPACE_RFILE);
  assign irOn    = irControl[IR_ENABLE];

  // Register writes
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < NUM_CH; i++) begin
        preset[i] <= RST_BYTE;
      end
      irqEnableMask   <= RST_BYTE;
      timeBaseControl <= RST_BYTE;
      cnt12Ctrl       <= RST_BYTE;
      pulseCtrl       <= RST_BYTE;
      counterRun      <= 4'h0;
      irControl       <= RST_BYTE;
    end else begin
      if (wrIoc0) begin
        case (regReq.addr)
          A_CNT1_PRESET: preset[CH_CNT1] <= regReq.wdata;
          A_CNT2_PRESET: preset[CH_CNT2] <= regReq.wdata;
          A_HIGH_PRESET: preset[CH_HIGH] <= regReq.wdata;
          A_LOW_PRESET:  preset[CH_LOW]  <= regReq.wdata;
          A_IRQ_MASK:    irqEnableMask   <= regReq.wdata;
          default: ;
        endcase
      end
      if (wrIoc1) begin
        case (regReq.addr)
          A_TB_CONTROL: timeBaseControl <= regReq.wdata;
          A_CNT12_CTRL: cnt12Ctrl       <= regReq.wdata;
          A_PULSE_CTRL: pulseCtrl       <= regReq.wdata;
          default: ;
        endcase
      end
      if (wrRfile) begin
        case (regReq.addr)
          A_COUNTER_RUN: counterRun <= regReq.wdata[3:0];
          A_IR_CONTROL:  irControl  <= regReq.wdata & IR_WR_MASK;
          default: ;
        endcase
      end
    end
  end

  // Global interrupt enable, changed only by instructions and interrupt entry
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      globalIrqEn <= 1'b0;
    end else if (gieCtl.irqOff || gieCtl.irqEntry) begin
      globalIrqEn <= 1'b0;
    end else if (gieCtl.irqOn || gieCtl.irqRet) begin
      globalIrqEn <= 1'b1;
    end
  end

  // Four down-counters
  generate
    for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
      logic [3:0] ckNib;
      logic       srcTick;
      assign ckNib   = (ch < CH_HIGH) ? cnt12Ctrl[(ch % 2) * NIB +: NIB]
                                      : pulseCtrl[(ch % 2) * NIB +: NIB];
      assign srcTick = ckNib[CK_SRC] ? ticks.fm : ticks.fs;
      tmr_down_counter u_cnt (
        .mclk      (mclk),
        .sys_rst   (sys_rst),
        .run       (chRun[ch]),
        .srcTick   (srcTick),
        .psCode    (ckNib[CK_PS_HI:0]),
        .preset    (preset[ch]),
        .underflow (uf[ch]),
        .count     (cntVal[ch])
      );
    end
  endgenerate

  // Pulse timers run only in their own phase while the output is on
  always_comb begin
    chRun[CH_CNT1] = counterRun[CH_CNT1];
    chRun[CH_CNT2] = counterRun[CH_CNT2];
    chRun[CH_HIGH] = counterRun[CH_HIGH] && (!irOn || (phase == PH_HIGH));
    chRun[CH_LOW]  = counterRun[CH_LOW] && (!irOn || (phase == PH_LOW));
  end

  // Output phase sequencing
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      phase <= PH_HIGH;
    end else if (!irOn) begin
      phase <= irControl[IR_LOW_ONLY] ? PH_LOW : PH_HIGH;
    end else begin
      case (phase)
        PH_HIGH: begin
          if (irControl[IR_LOW_ONLY]) begin
            phase <= PH_LOW;
          end else if (uf[CH_HIGH]) begin
            phase <= PH_LOW;
          end
        end
        PH_LOW: begin
          if (uf[CH_LOW] && !irControl[IR_LOW_ONLY]) begin
            phase <= PH_HIGH;
          end
        end
        default: phase <= PH_HIGH;
      endcase
    end
  end

  // Carrier toggles on each counter 2 underflow
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      carrier <= 1'b0;
    end else if (!counterRun[CH_CNT2]) begin
      carrier <= 1'b0;
    end else if (uf[CH_CNT2]) begin
      carrier <= ~carrier;
    end
  end

  // Output pin
  always_comb begin
    if (!irOn) begin
      next_ir_output_pin = 1'b0;
    end else if (phase == PH_HIGH) begin
      next_ir_output_pin = 1'b1;
    end else if (irControl[IR_MOD_EN]) begin
      next_ir_output_pin = carrier;
    end else begin
      next_ir_output_pin = 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      irOutputPin <= 1'b0;
      irOutputEn  <= 1'b0;
    end else begin
      irOutputPin <= next_ir_output_pin;
      irOutputEn  <= irOn && irControl[IR_PIN_EN];
    end
  end

  // Pin synchronisers and edge detection
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      extSync1 <= 1'b0;
      extSync2 <= 1'b0;
      extSync3 <= 1'b0;
      i0Sync1  <= 1'b0;
      i0Sync2  <= 1'b0;
      i0Sync3  <= 1'b0;
    end else begin
      extSync1 <= extCountPin;
      extSync2 <= extSync1;
      extSync3 <= extSync2;
      i0Sync1  <= extIrq0Pin;
      i0Sync2  <= i0Sync1;
      i0Sync3  <= i0Sync2;
    end
  end

  assign extEdge  = timeBaseControl[TB_EDGE] ? (extSync3 && !extSync2)
                                             : (!extSync3 && extSync2);
  assign ext0Edge = timeBaseControl[TB_INT_EDGE] ? (i0Sync3 && !i0Sync2)
                                                 : (!i0Sync3 && i0Sync2);

  // Time base counter with prescaler
  assign tbEvent   = timeBaseControl[TB_SRC] ? extEdge : ticks.instr;
  assign tbPsLimit = ~(8'(PS_MASK_BASE << timeBaseControl[TB_PS_HI:0]));
  assign tbTick    = tbEvent && (!timeBaseControl[TB_PS_ON]
                                 || (tbPsCnt == tbPsLimit));

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      tbPsCnt         <= RST_BYTE;
      timeBaseCounter <= RST_BYTE;
    end else if (wrRfile && (regReq.addr == A_TB_COUNTER)) begin
      tbPsCnt         <= RST_BYTE;
      timeBaseCounter <= regReq.wdata;
    end else begin
      if (tbTick || !timeBaseControl[TB_PS_ON]) begin
        tbPsCnt <= RST_BYTE;
      end else if (tbEvent) begin
        tbPsCnt <= tbPsCnt + 8'h01;
      end
      if (tbTick) begin
        timeBaseCounter <= timeBaseCounter + 8'h01;
      end
    end
  end

  // Status flags; an event in the clearing cycle wins
  always_comb begin
    setEvents                        = RST_BYTE;
    setEvents[ST_TB]                 = tbTick && (timeBaseCounter == TB_MAX);
    setEvents[ST_EXT0]               = ext0Edge && irControl[IR_EXT0_EN];
    setEvents[ST_EXT1]               = extIrq1Evt;
    setEvents[ST_CH_BASE +: NUM_CH]  = uf;
    setEvents[ST_PORT]               = portChangeEvt;
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      irqStatus <= RST_BYTE;
    end else if (wrRfile && (regReq.addr == A_IRQ_STATUS)) begin
      irqStatus <= (irqStatus & regReq.wdata) | setEvents;
    end else begin
      irqStatus <= irqStatus | setEvents;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      irqReq <= 1'b0;
    end else begin
      irqReq <= |(irqStatus & irqEnableMask);
    end
  end

  // Read data
  always_comb begin
    next_rdata = RST_BYTE;
    case (regReq.space)
      SPACE_IOC0: begin
        case (regReq.addr)
          A_CNT1_PRESET: next_rdata = preset[CH_CNT1];
          A_CNT2_PRESET: next_rdata = preset[CH_CNT2];
          A_HIGH_PRESET: next_rdata = preset[CH_HIGH];
          A_LOW_PRESET:  next_rdata = preset[CH_LOW];
          A_IRQ_MASK:    next_rdata = irqEnableMask;
          default:       next_rdata = RST_BYTE;
        endcase
      end
      SPACE_IOC1: begin
        case (regReq.addr)
          A_TB_CONTROL: begin
            next_rdata         = timeBaseControl;
            next_rdata[TB_GIE] = globalIrqEn;
          end
          A_CNT12_CTRL: next_rdata = cnt12Ctrl;
          A_PULSE_CTRL: next_rdata = pulseCtrl;
          default:      next_rdata = RST_BYTE;
        endcase
      end
      SPACE_RFILE: begin
        case (regReq.addr)
          A_TB_COUNTER:  next_rdata = timeBaseCounter;
          A_COUNTER_RUN: next_rdata = {4'h0, counterRun};
          A_IR_CONTROL:  next_rdata = irControl;
          A_IRQ_STATUS:  next_rdata = irqStatus;
          default:       next_rdata = RST_BYTE;
        endcase
      end
      default: next_rdata = RST_BYTE;
    endcase
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      regRdata <= RST_BYTE;
    end else if (regReq.re) begin
      regRdata <= next_rdata;
    end
  end

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  sequence s_highDone;
    irOn && (phase == PH_HIGH) && uf[CH_HIGH] && !irControl[IR_LOW_ONLY];
  endsequence

  sequence s_lowDone;
    irOn && (phase == PH_LOW) && uf[CH_LOW];
  endsequence

  property p_reload1;
    uf[CH_CNT1] |-> (cntVal[CH_CNT1] == $past(preset[CH_CNT1]));
  endproperty
  a_reload1: assert property (p_reload1) else $error("counter 1 did not reload");

  property p_carrier;
    uf[CH_CNT2] && counterRun[CH_CNT2] |=> (carrier != $past(carrier));
  endproperty
  a_carrier: assert property (p_carrier) else $error("carrier did not toggle");

  property p_highEnd;
    s_highDone |=> (phase == PH_LOW) ##1 !irOutputPin || irControl[IR_MOD_EN];
  endproperty
  a_highEnd: assert property (p_highEnd) else $error("high phase did not end");

  property p_lowEnd;
    s_lowDone ##0 !irControl[IR_LOW_ONLY] |=> (phase == PH_HIGH) ##1 irOutputPin;
  endproperty
  a_lowEnd: assert property (p_lowEnd) else $error("low phase did not end");

  property p_lowOnly;
    s_lowDone ##0 irControl[IR_LOW_ONLY] |=> (phase == PH_LOW);
  endproperty
  a_lowOnly: assert property (p_lowOnly) else $error("low-only left low phase");

  property p_modulate;
    irOn && (phase == PH_LOW) && irControl[IR_MOD_EN] |=> (irOutputPin == $past(carrier));
  endproperty
  a_modulate: assert property (p_modulate) else $error("low phase not modulated");

  property p_flagSet;
    uf[CH_CNT1] |=> irqStatus[ST_CH_BASE];
  endproperty
  a_flagSet: assert property (p_flagSet) else $error("counter 1 flag not set");

  property p_request;
    (|(irqStatus & irqEnableMask)) |=> irqReq;
  endproperty
  a_request: assert property (p_request) else $error("request missing");

  property p_noRequest;
    !(|(irqStatus & irqEnableMask)) |=> !irqReq;
  endproperty
  a_noRequest: assert property (p_noRequest) else $error("request without cause");

  property p_gieOff;
    gieCtl.irqOff |=> !globalIrqEn;
  endproperty
  a_gieOff: assert property (p_gieOff) else $error("global enable not cleared");

  property p_tbWrap;
    tbTick && (timeBaseCounter == TB_MAX) && !wrRfile |=>
      (timeBaseCounter == RST_BYTE) && irqStatus[ST_TB];
  endproperty
  a_tbWrap: assert property (p_tbWrap) else $error("time base overflow wrong");

endmodule

/* verif/testbench.sv */
/*
  Self-checking bench for the timer block: register tasks, tick pulses,
  counter, time base, external interrupt 0 and IR/PWM scenarios.
  Assumes 20 MHz mclk; main oscillator tick every second cycle.
*/
`timescale 1ns/100ps
module testbench;
  import tmr_pkg::*;
  logic         mclk;
  logic         sys_rst;
  tmr_reg_req_t regReq;
  tmr_ticks_t   ticks;
  tmr_gie_ctl_t gieCtl;
  logic         fsTick, fmTick, instrTick, fmOn;
  logic         extCountPin, extIrq0Pin, extIrq1Evt, portChangeEvt;
  logic [7:0]   regRdata;
  logic         irOutputPin, irOutputEn, irqReq;
  int           hiLen, loLen, runLen, miscompares, n_checks, cycles;
  logic [3:0]   gieCode [4] = '{4'h4, 4'h8, 4'h2, 4'h1};
  logic [7:0]   gieExp [4]  = '{8'hFF, 8'hBF, 8'hFF, 8'hBF};
  logic [7:0]   psCtl [3]   = '{8'h00, 8'h08, 8'h0A};
  int           psN [3]     = '{5, 16, 16};

  assign ticks = '{fs: fsTick, fm: fmTick, instr: instrTick};

  tmr_timer_block dut (.mclk(mclk), .sys_rst(sys_rst), .regReq(regReq), .ticks(ticks),
    .gieCtl(gieCtl), .extCountPin(extCountPin), .extIrq0Pin(extIrq0Pin),
    .extIrq1Evt(extIrq1Evt), .portChangeEvt(portChangeEvt), .regRdata(regRdata),
    .irOutputPin(irOutputPin), .irOutputEn(irOutputEn), .irqReq(irqReq));

  tmr_ir_load partner (.mclk(mclk), .sys_rst(sys_rst), .irOutputPin(irOutputPin),
    .extCountPin(extCountPin), .hiLen(hiLen), .loLen(loLen), .runLen(runLen));

  initial mclk = 1'b0;
  always #25 mclk = ~mclk;
  always @(posedge mclk) fmTick <= #1 fmOn & ~fmTick;

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 10000) begin
      miscompares++;
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [1:0] sp, input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    #1 regReq = '{we: 1'b1, re: 1'b0, space: sp, addr: a, wdata: d};
    @(posedge mclk);
    #1 regReq.we = 1'b0;
  endtask

  task automatic rdc(input string nm, input logic [1:0] sp, input logic [3:0] a,
                     input logic [7:0] exp);
    @(posedge mclk);
    #1 regReq = '{we: 1'b0, re: 1'b1, space: sp, addr: a, wdata: 8'h00};
    @(posedge mclk);
    #1 regReq.re = 1'b0;
    chk(nm, exp, regRdata);
  endtask

  // Sel 0 pulses the sub-oscillator tick, else the instruction tick
  task automatic pulse(input int sel, input int n);
    repeat (n) begin
      @(posedge mclk);
      #1 if (sel == 0) fsTick = 1'b1; else instrTick = 1'b1;
      @(posedge mclk);
      #1 fsTick = 1'b0;
      instrTick = 1'b0;
    end
    repeat (4) @(posedge mclk);
  endtask

  task automatic gie(input logic [3:0] c);
    @(posedge mclk);
    #1 gieCtl = c;
    @(posedge mclk);
    #1 gieCtl = '0;
  endtask

  initial begin
    regReq = '0;
    gieCtl = '0;
    {fsTick, fmTick, instrTick, fmOn} = 4'h0;
    {extIrq0Pin, extIrq1Evt, portChangeEvt} = 3'h0;
    sys_rst = 1'b1;
    repeat (12) @(posedge mclk);
    #1 sys_rst = 1'b0;
    for (int i = 0; i < 5; i++) begin
      wr(SPACE_IOC0, 4'(4'hB + i), 8'(8'hA5 ^ i));
      rdc("ioc0", SPACE_IOC0, 4'(4'hB + i),
          8'(8'hA5 ^ i));
    end
    rdc("unmapped", 2'h3, 4'h0, 8'h00);
    wr(SPACE_IOC1, A_TB_CONTROL, 8'hFF);
    rdc("gie", SPACE_IOC1, A_TB_CONTROL, 8'hBF);
    for (int i = 0; i < 4; i++) begin
      gie(gieCode[i]);
      rdc("gie", SPACE_IOC1, A_TB_CONTROL, gieExp[i]);
    end
    for (int i = 0; i < 3; i++) begin
      wr(SPACE_IOC1, A_TB_CONTROL, psCtl[i]);
      wr(SPACE_RFILE, A_TB_COUNTER, 8'h00);
      pulse(1, psN[i]);
      rdc("tbcount", SPACE_RFILE, A_TB_COUNTER,
          8'(psN[i] / (i == 0 ? 1 : 2 << (i - 1) * 2)));
    end
    wr(SPACE_IOC1, A_TB_CONTROL, 8'h00);
    wr(SPACE_RFILE, A_TB_COUNTER, 8'hFE);
    pulse(1, 2);
    rdc("tbwrap", SPACE_RFILE, A_TB_COUNTER, 8'h00);
    rdc("status", SPACE_RFILE, A_IRQ_STATUS, 8'h01);
    wr(SPACE_RFILE, A_IRQ_STATUS, 8'h00);
    wr(SPACE_IOC1, A_TB_CONTROL, 8'h20);
    wr(SPACE_RFILE, A_TB_COUNTER, 8'h00);
    partner.toggle_pin(5);
    repeat (8) @(posedge mclk);
    rdc("extrise", SPACE_RFILE, A_TB_COUNTER, 8'h03);
    wr(SPACE_IOC1, A_TB_CONTROL, 8'h30);
    wr(SPACE_RFILE, A_TB_COUNTER, 8'h00);
    partner.toggle_pin(5);
    repeat (8) @(posedge mclk);
    rdc("extfall", SPACE_RFILE, A_TB_COUNTER, 8'h03);
    wr(SPACE_IOC1, A_TB_CONTROL, 8'h00);
    wr(SPACE_RFILE, A_IR_CONTROL, 8'h01);
    wr(SPACE_RFILE, A_IRQ_STATUS, 8'h00);
    extIrq1Evt = 1'b1;
    portChangeEvt = 1'b1;
    @(posedge mclk);
    #1 {extIrq1Evt, portChangeEvt} = 2'h0;
    extIrq0Pin = 1'b1;
    repeat (8) @(posedge mclk);
    rdc("events", SPACE_RFILE, A_IRQ_STATUS, 8'h86);
    wr(SPACE_IOC1, A_TB_CONTROL, 8'h80);
    wr(SPACE_RFILE, A_IRQ_STATUS, 8'h00);
    extIrq0Pin = 1'b0;
    repeat (8) @(posedge mclk);
    rdc("ext0fall", SPACE_RFILE, A_IRQ_STATUS, 8'h02);
    wr(SPACE_RFILE, A_IRQ_STATUS, 8'h00);
    extIrq0Pin = 1'b1;
    repeat (8) @(posedge mclk);
    rdc("ext0rise", SPACE_RFILE, A_IRQ_STATUS, 8'h00);
    wr(SPACE_IOC1, A_CNT12_CTRL, 8'h80);
    wr(SPACE_IOC0, A_CNT1_PRESET, 8'h02);
    wr(SPACE_IOC0, A_IRQ_MASK, 8'h08);
    wr(SPACE_RFILE, A_COUNTER_RUN, 8'h01);
    for (int k = 0; k < 2; k++) begin
      pulse(0, 5);
      rdc("cnt1early", SPACE_RFILE, A_IRQ_STATUS, 8'h00);
      pulse(0, 1);
      rdc("cnt1flag", SPACE_RFILE, A_IRQ_STATUS, 8'h08);
      chk("irq", 8'h01, {7'h0, irqReq});
      wr(SPACE_RFILE, A_IRQ_STATUS, 8'h00);
    end
    wr(SPACE_IOC0, A_IRQ_MASK, 8'h00);
    pulse(0, 6);
    chk("irqmasked", 8'h00, {7'h0, irqReq});
    wr(SPACE_RFILE, A_COUNTER_RUN, 8'h00);
    wr(SPACE_RFILE, A_IRQ_STATUS, 8'h00);
    pulse(0, 8);
    rdc("stopped", SPACE_RFILE, A_IRQ_STATUS, 8'h00);
    wr(SPACE_IOC0, A_CNT2_PRESET, 8'h00);
    wr(SPACE_IOC0, A_HIGH_PRESET, 8'h03);
    wr(SPACE_IOC0, A_LOW_PRESET, 8'h01);
    wr(SPACE_IOC1, A_PULSE_CTRL, 8'h88);
    fmOn = 1'b1;
    wr(SPACE_RFILE, A_COUNTER_RUN, 8'h0E);
    wr(SPACE_RFILE, A_IR_CONTROL, 8'h88);
    repeat (120) @(posedge mclk);
    chk("highlen", 8'(2 * 2 * (3 + 1)), 8'(hiLen));
    chk("lowlen", 8'(2 * 2 * (1 + 1)), 8'(loLen));
    chk("outen", 8'h01, {7'h0, irOutputEn});
    wr(SPACE_RFILE, A_IR_CONTROL, 8'hA8);
    repeat (80) @(posedge mclk);
    chk("lowonly", 8'h01, {7'h0, irOutputPin === 1'b0 && runLen > 60});
    wr(SPACE_RFILE, A_IR_CONTROL, 8'hE8);
    repeat (80) @(posedge mclk);
    chk("carrierhi", 8'(2 * 2 * (0 + 1)), 8'(hiLen));
    chk("carrierlo", 8'(2 * 2 * (0 + 1)), 8'(loLen));
    test_done();
  end
endmodule

/* verif/tmr_ir_load.sv */
/*
  Far-side model: the IR/PWM load, which measures each output level,
  and the external count pin source.
  Assumes the bench clock and reset; pin moves 1 ns after an edge.
*/
`timescale 1ns/100ps
module tmr_ir_load (
  input  wire logic mclk,
  input  wire logic sys_rst,
  input  wire logic irOutputPin,
  output logic      extCountPin,
  output int        hiLen,
  output int        loLen,
  output int        runLen
);
  logic prevLevel;

  initial extCountPin = 1'b0;

  // Half period of 4 cycles, far above the instruction period
  task automatic toggle_pin(input int n);
    for (int i = 0; i < n; i++) begin
      repeat (4) @(posedge mclk);
      #1 extCountPin = ~extCountPin;
    end
  endtask

  // Length in cycles of the last high and low level seen
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      prevLevel <= 1'b0;
      runLen    <= 0;
      hiLen     <= 0;
      loLen     <= 0;
    end else begin
      prevLevel <= irOutputPin;
      if (irOutputPin === prevLevel) begin
        runLen <= runLen + 1;
      end else begin
        if (prevLevel) hiLen <= runLen;
        else loLen <= runLen;
        runLen <= 1;
      end
    end
  end
endmodule
